/* File: common/madc_pkg.sv */
package madc_pkg;
  // ==========================================================
  // Channel word layout
  // ==========================================================
  localparam int WORD_BITS = 4;        // Stored channel word width
  localparam int EN_POS = 3;           // First bit shifted in is the enable
  localparam int CH_MSB = 2;           // Channel number, msb first
  localparam int RESULT_BITS = 12;     // Conversion result width
  localparam int NULL_BITS = 1;        // Null bits before the result
  localparam int HOLD_FALL = 2;        // Falling edge that ends sampling
  localparam int TAKEOVER_FALL = 6;    // Latest falling edge to own the line
  // ==========================================================
  // Switch timing, in nanoseconds, and the clock period
  // ==========================================================
  localparam int CLK_PERIOD_NS = 20;
  localparam int TURN_OFF_NS = 300;    // Longest turn-off delay
  localparam int BREAK_NS = 35;        // Least break interval
  localparam int TURN_ON_NS = TURN_OFF_NS + BREAK_NS;
  // Longest time rounds down, least time rounds up, never below one
  localparam int OFF_CYC_RAW = TURN_OFF_NS / CLK_PERIOD_NS;
  localparam int OFF_CYC = (OFF_CYC_RAW < 1) ? 1 : OFF_CYC_RAW;
  localparam int ON_CYC = OFF_CYC + (BREAK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WORD_RST = 4'h0;
  localparam logic [11:0] RESULT_RST = 12'h000;
endpackage

/* File: core/madc_shift_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// Two-flop synchroniser for a group of pin inputs
module madc_shift_sync #(
  parameter int WIDTH = 4
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;            // First stage, read only by the second
  // ==========================================================
  // Two stages; reset value is a constant
  // ==========================================================
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      meta_r <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_r <= async_in;
      sync_out <= meta_r;
    end
  end
endmodule // madc_shift_sync
`default_nettype wire

/* File: core/madc_serial_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
// How it works
// [RL1] Send on falling, sample on rising edge
// [RL2] Take channel word, then return result
// [RL3] Data in and out may share wire
// [RL4] Select high shifts input into 4 bits
// [RL5] Keep last four bits before select falls
// [RL6] Host drops select before next rising edge
// [RL7] Select falling opens all channels first
// [RL8] Addressed channel connects after turn-on delay
// [RL9] Channel stays on until next select fall
// [RL10] Enable low keeps all channels open
// [RL11] One null bit precedes the result
// [RL12] Result is twelve bits wide
// [RL13] Select high resets and starts exchange
// [RL14] Converter select high: powered down, output off
// [RL15] Channel select high accepts address; low connects
// [RL16] Host ties both selects together
// [RL17] Shift clock steps the conversion
// [RL18] First word bit is the enable
// [RL19] Next three bits: channel number, msb first
// [RL20] Device owns shared line before sixth fall
// [RL21] Sample until second falling edge, then hold
// [RL22] Input ignored while select is low
module madc_serial_ctrl #(
  parameter int CHANNELS = 8,
  parameter int OFF_CYCLES = madc_pkg::OFF_CYC,
  parameter int ON_CYCLES = madc_pkg::ON_CYC
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic shift_clk_in,           // Shift clock from host
  input wire logic converter_select_n_in,  // Converter select, active low
  input wire logic channel_select_n_in,    // Channel select, active low
  input wire logic data_in,                // Serial input (or shared wire level)
  input wire logic comparator_in,          // Successive-approximation comparator
  output logic data_out,                   // Serial output
  output logic data_oe_out,                // High while the device drives data
  output logic [CHANNELS-1:0] channel_on_out, // One-hot channel switches
  output logic converter_power_out,        // Converter bias enabled
  output logic sample_out,                 // Sample-and-hold tracking
  output logic [11:0] trial_code_out,      // DAC code under trial
  output logic [11:0] result_out,          // Last finished result
  output logic result_valid_out            // One-cycle pulse at completion
);
  // ==========================================================
  // Input synchronisation
  // ==========================================================
  logic [3:0] sync_w;
  madc_shift_sync #(.WIDTH(4)) u_sync (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .async_in({shift_clk_in, converter_select_n_in, channel_select_n_in, data_in}),
    .sync_out(sync_w)
  );
  wire sck_w = sync_w[3];
  wire converter_select_n_w = sync_w[2];
  wire channel_select_n_w = sync_w[1];
  wire din_w = sync_w[0];

  logic sck_d_r, converter_select_n_d_r, channel_select_n_d_r;      // Previous samples for edge finding
  wire sck_rise_w = sck_w & ~sck_d_r;
  wire sck_fall_w = ~sck_w & sck_d_r;
  wire mux_fall_w = ~channel_select_n_w & channel_select_n_d_r;
  wire adc_fall_w = ~converter_select_n_w & converter_select_n_d_r;

  // ==========================================================
  // Channel word capture
  // ==========================================================
  logic [3:0] word_r;                       // Stored channel word
  logic [3:0] latched_r;                    // Word frozen at select fall
  wire en_w = latched_r[madc_pkg::EN_POS];              // [RL18]
  wire [2:0] chan_w = latched_r[madc_pkg::CH_MSB:0];    // [RL19]

  // Keeps shifting while high; the latest four bits win
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      word_r <= madc_pkg::WORD_RST;
    else if (channel_select_n_w && sck_rise_w)                     // [RL22]
      word_r <= {word_r[2:0], din_w};                   // [RL1] [RL4] [RL5] [RL15]
  end

  // ==========================================================
  // Break-before-make switch timing
  // ==========================================================
  typedef enum logic [1:0] {SW_IDLE, SW_OFF, SW_BREAK, SW_ON} madc_sw_e;
  madc_sw_e sw_r;
  logic [15:0] sw_cnt_r;
  wire [15:0] off_lim_w = 16'(OFF_CYCLES);
  wire [15:0] on_lim_w = 16'(ON_CYCLES);
  // Last cycle of the break: SW_ON follows when the enable is set (SW_IDLE otherwise), and the addressed channel connects a cycle later
  wire turn_on_w = (sw_r == SW_BREAK) && (sw_cnt_r >= on_lim_w);

  // Old channel stays on through the turn-off delay after each fall
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      sw_r <= SW_IDLE;
      sw_cnt_r <= 16'h0000;
      latched_r <= madc_pkg::WORD_RST;
    end
    else if (mux_fall_w)                                // [RL7]
    begin
      sw_r <= SW_OFF;
      sw_cnt_r <= 16'h0001;
      latched_r <= word_r;
    end
    else
    begin
      unique case (sw_r)
        SW_IDLE: sw_cnt_r <= 16'h0000;
        SW_OFF:
        begin
          sw_cnt_r <= sw_cnt_r + 16'h0001;
          if (sw_cnt_r >= off_lim_w)
            sw_r <= SW_BREAK;
        end
        SW_BREAK:
        begin
          sw_cnt_r <= sw_cnt_r + 16'h0001;
          if (sw_cnt_r >= on_lim_w)
            sw_r <= en_w ? SW_ON : SW_IDLE;             // [RL8] [RL10]
        end
        SW_ON: sw_cnt_r <= 16'h0000;                    // [RL9]
      endcase
    end
  end

  // Channel decoder: connect only in the on state
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      channel_on_out <= '0;
    else if (sw_r == SW_ON)
      channel_on_out <= CHANNELS'(1) << chan_w;         // [RL8]
    else if (sw_r == SW_BREAK || (sw_r == SW_IDLE && !en_w))
      channel_on_out <= '0;                             // [RL7] [RL10]
  end

  // ==========================================================
  // Conversion and readout sequence, paced by shift clock
  // ==========================================================
  typedef enum logic [2:0] {CV_DOWN, CV_SAMPLE, CV_CONV, CV_TAIL} madc_cv_e;
  madc_cv_e cv_r;
  logic [3:0] fall_cnt_r;                   // Falling edges since select fell
  logic [3:0] bit_r;                        // Bit under trial
  logic [11:0] sar_r;                       // Approximation register

  // Select high is a reset of the converter side
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in || converter_select_n_w)                            // [RL13] [RL14]
    begin
      cv_r <= CV_DOWN;
      fall_cnt_r <= 4'h0;
      bit_r <= 4'hB;
      sar_r <= madc_pkg::RESULT_RST;
      data_oe_out <= 1'b0;
      data_out <= 1'b0;
      converter_power_out <= 1'b0;
      sample_out <= 1'b0;
      result_valid_out <= 1'b0;
    end
    else
    begin
      result_valid_out <= 1'b0;
      converter_power_out <= (cv_r != CV_TAIL);
      // Tracking opens as the break ends, one cycle before the channel
      // switch closes, so no charge from the break lands on the hold capacitor
      if (turn_on_w && cv_r == CV_SAMPLE)
        sample_out <= 1'b1;                             // [RL21]
      if (adc_fall_w)
        cv_r <= CV_SAMPLE;
      else if (sck_fall_w)
      begin
        if (fall_cnt_r != 4'hF)
          fall_cnt_r <= fall_cnt_r + 4'h1;
        unique case (cv_r)
          CV_DOWN: cv_r <= CV_DOWN;
          CV_SAMPLE:
            if (fall_cnt_r == 4'(madc_pkg::HOLD_FALL - 1))
            begin
              sample_out <= 1'b0;                       // [RL21]
              data_oe_out <= 1'b1;                      // [RL20] [RL3]
              data_out <= 1'b0;                         // [RL11]
              // Trial code is loaded with the null bit, so the very
              // next fall already puts out the most significant bit
              sar_r <= 12'h800;                         // [RL17]
              bit_r <= 4'hB;
              cv_r <= CV_CONV;
            end
          CV_CONV:
          begin
            // Decide the bit under trial, put it out, try the next
            sar_r[bit_r] <= comparator_in;
            data_out <= comparator_in;                  // [RL1] [RL2] [RL12]
            if (bit_r == 4'h0)
            begin
              cv_r <= CV_TAIL;
              result_valid_out <= 1'b1;
            end
            else
            begin
              sar_r[bit_r - 4'h1] <= 1'b1;              // [RL17]
              bit_r <= bit_r - 4'h1;
            end
          end
          CV_TAIL: data_out <= 1'b0;                    // Zeroes after result
        endcase
      end
    end
  end

  // Trial code and finished result
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      trial_code_out <= madc_pkg::RESULT_RST;
      result_out <= madc_pkg::RESULT_RST;
    end
    else
    begin
      trial_code_out <= sar_r;
      if (result_valid_out)
        result_out <= sar_r;
    end
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      sck_d_r <= 1'b1;
      converter_select_n_d_r <= 1'b1;
      channel_select_n_d_r <= 1'b1;
    end
    else
    begin
      sck_d_r <= sck_w;
      converter_select_n_d_r <= converter_select_n_w;
      channel_select_n_d_r <= channel_select_n_w;
    end
  end
endmodule // madc_serial_ctrl
`default_nettype wire

/* File: dv/madc_serial_props.sv */
`timescale 1ns/1ns
`default_nettype none
// =========================================
// Pin checks for the serial control block
module madc_serial_props #(
  parameter int CHANNELS = 8,
  parameter int OFF_CYCLES = 15,
  parameter int ON_CYCLES = 17
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic channel_select_n_in,
  input wire logic converter_select_n_in,
  input wire logic data_oe_out,
  input wire logic converter_power_out,
  input wire logic sample_out,
  input wire logic result_valid_out,
  input wire logic [CHANNELS-1:0] channel_on_out
);
  logic sel_d_r; // Select one cycle ago
  logic [7:0] since_fall_r; // Cycles since select fell, saturating
  // Counter spans the sync delay so bounds stay loose
  always_ff @(posedge sys_clk_in)
  begin
    sel_d_r <= channel_select_n_in;
    if (reset_in || (sel_d_r && !channel_select_n_in))
      since_fall_r <= 8'h00;
    else if (since_fall_r != 8'hFF)
      since_fall_r <= since_fall_r + 8'h01;
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  sequence sel_hi_run;
    converter_select_n_in [*6];
  endsequence
  chk_oe_released: assert property (sel_hi_run |-> !data_oe_out)
    else $error("data driven while select high");
  chk_power_down: assert property (sel_hi_run |-> !converter_power_out)
    else $error("converter powered while select high");
  chk_one_hot: assert property ($onehot0(channel_on_out))
    else $error("more than one channel on");
  chk_chan_hold: assert property ((channel_on_out != $past(channel_on_out))
    && ($past(channel_on_out) != '0) |-> since_fall_r <= OFF_CYCLES + 8)
    else $error("channel dropped without select fall");
  chk_make_break: assert property ($rose(|channel_on_out)
    |-> since_fall_r >= ON_CYCLES && since_fall_r <= ON_CYCLES + 8)
    else $error("channel on at wrong time");
  chk_valid_pulse: assert property (result_valid_out |=> !result_valid_out)
    else $error("valid longer than one cycle");
  chk_valid_oe: assert property (result_valid_out |-> data_oe_out)
    else $error("result done while line not driven");
  chk_oe_rise: assert property ($rose(data_oe_out)
    |-> !converter_select_n_in && since_fall_r >= 8'h02)
    else $error("line taken before select fell");
  chk_sample_start: assert property ($rose(sample_out) |-> since_fall_r >= ON_CYCLES)
    else $error("sampling before channel on");
endmodule // madc_serial_props
bind madc_serial_ctrl madc_serial_props #(.CHANNELS(CHANNELS), .OFF_CYCLES(OFF_CYCLES),
  .ON_CYCLES(ON_CYCLES)) u_props (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .channel_select_n_in(channel_select_n_in), .converter_select_n_in(converter_select_n_in),
  .data_oe_out(data_oe_out), .converter_power_out(converter_power_out),
  .sample_out(sample_out), .result_valid_out(result_valid_out),
  .channel_on_out(channel_on_out));
`default_nettype wire

/* File: dv/madc_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
// =========================================
// Host driving select, shift clock and data
module madc_host_model (
  input wire logic sys_clk_in,
  input wire logic data_line_in,
  input wire logic [11:0] trial_code_in,
  output logic shift_clk_out,
  output logic select_n_out,
  output logic host_oe_out,
  output logic host_d_out,
  output logic comparator_out
);
  logic [11:0] level_r = 12'h000; // Analog level on the chosen channel
  logic [17:0] seen_r = '0; // Bits taken on rises after select fell
  initial
  begin
    shift_clk_out = 1'b0;
    select_n_out = 1'b1;
    host_oe_out = 1'b0;
    host_d_out = 1'b0;
  end
  // Ideal comparator keeps a trial bit when not above the level
  assign comparator_out = (trial_code_in <= level_r);
  task automatic half();
    repeat (8) @(negedge sys_clk_in);
  endtask
  // Two junk bits lead, so only the last four should stick
  task automatic send(input logic [5:0] bits);
    for (int i = 5; i >= 0; i--)
    begin
      host_oe_out = 1'b1;
      host_d_out = bits[i];
      half();
      shift_clk_out = 1'b1;
      half();
      shift_clk_out = 1'b0;
    end
  endtask
  // Both selects move as one; line released at once
  task automatic drop();
    host_oe_out = 1'b0;
    select_n_out = 1'b0;
  endtask
  task automatic clock_out();
    for (int i = 0; i < 18; i++)
    begin
      half();
      shift_clk_out = 1'b1;
      seen_r = {seen_r[16:0], data_line_in};
      half();
      shift_clk_out = 1'b0;
    end
  endtask
  task automatic raise();
    half();
    select_n_out = 1'b1;
  endtask
endmodule // madc_host_model
`default_nettype wire

/* File: dv/tb.sv */
`timescale 1ns/1ns
`default_nettype none
// =========================================
// Testbench top
module tb;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic last_r = 1'b0; // Last driven line level
  wire logic sck, sel_n, h_oe, h_d, cmp, d_out, d_oe, pwr, smp, vld, line;
  wire logic [7:0] chan_on;
  wire logic [11:0] trial, result;
  int n_mismatch = 0;
  int checks = 0;
  // Undriven shared line shows the inverse of its last level
  assign line = d_oe ? d_out : (h_oe ? h_d : ~last_r);
  always @(negedge sys_clk_in)
    if (d_oe || h_oe)
      last_r <= line;
  initial
  begin
    forever #10 sys_clk_in = ~sys_clk_in;
  end
  madc_serial_ctrl #(.CHANNELS(8), .OFF_CYCLES(3), .ON_CYCLES(5)) u_dut (
    .sys_clk_in(sys_clk_in), .reset_in(reset_in), .shift_clk_in(sck),
    .converter_select_n_in(sel_n), .channel_select_n_in(sel_n), .data_in(line),
    .comparator_in(cmp), .data_out(d_out), .data_oe_out(d_oe), .channel_on_out(chan_on),
    .converter_power_out(pwr), .sample_out(smp), .trial_code_out(trial),
    .result_out(result), .result_valid_out(vld));
  madc_host_model u_host (.sys_clk_in(sys_clk_in), .data_line_in(line),
    .trial_code_in(trial), .shift_clk_out(sck), .select_n_out(sel_n),
    .host_oe_out(h_oe), .host_d_out(h_d), .comparator_out(cmp));
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // One full exchange: word in, channel, serial result, release
  task automatic t_conv(input logic [5:0] word, input logic [11:0] level);
    logic [7:0] exp_on;
    exp_on = word[3] ? (8'h01 << word[2:0]) : 8'h00;
    u_host.level_r = level;
    u_host.send(word);
    u_host.drop();
    // With 3 off and 5 on cycles plus the sync, the break spans
    // the 7th and 8th edge and the channel shows from the 9th
    repeat (8) @(negedge sys_clk_in);
    check({4'h0, chan_on}, 12'h000);
    repeat (4) @(negedge sys_clk_in);
    check({4'h0, chan_on}, {4'h0, exp_on});
    u_host.clock_out();
    check({11'h000, u_host.seen_r[15]}, 12'h000);
    check(u_host.seen_r[14:3], level);
    check({9'h000, u_host.seen_r[2:0]}, 12'h000);
    check(result, level);
    check({4'h0, chan_on}, {4'h0, exp_on});
    u_host.raise();
    repeat (8) @(negedge sys_clk_in);
    check({10'h000, d_oe, pwr}, 12'h000);
    check({4'h0, chan_on}, {4'h0, exp_on});
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    n_mismatch++;
    close_out();
  end
  initial
  begin
    repeat (10) @(negedge sys_clk_in);
    reset_in = 1'b0;
    repeat (3) @(negedge sys_clk_in);
    for (int ch = 0; ch < 8; ch++)
      t_conv({3'h3, ch[2:0]}, ch[11:0] * 12'h249);
    t_conv(6'h35, 12'h5A3);
    close_out();
  end
endmodule // tb
`default_nettype wire
